// *** verilog/eic_top.v ***
// external interrupt conditioner with address trap routing and apb registers
// Functional notes
// - trapped fetch gives reset or trap interrupt
// - trap interrupt aborts running non-maskable service
// - five lines, each with noise filter
// - shared pin resets as port input
// - line 0 falls only, gated by select
// - lines 0,5 filter 2..7 fc, falling
// - line 1 reject 63 or 15 fc
// - line 1 accept 193 or 49 fc
// - lines 2,3 filter 7..25 fc
// - slow modes filter 1..3.5 fs
// - edge select bits 1..3, 1 falling
// - line enables need master and flag
// - latch set within accept plus 6 fs
// - output-use pins may fake requests
// - line 1 filter change within 26 fc
// - latch holds until accepted or cleared
`timescale 1ns/1ps
`include "eic_map.vh"
module eic_top (
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // external pins, asynchronous
    input wire extLine0Pin,
    input wire extLine1Pin,
    input wire extLine2Pin,
    input wire extLine3Pin,
    input wire extLine5Pin,
    input wire lowFreqClockPin,
    // core side
    input wire fetchTrapPulse,
    input wire nmiInService,
    input wire trapAck,
    input wire [4:0] irqAccept,
    // results
    output reg [4:0] irqRequest_r,
    output reg [4:0] irqLatch_r,
    output reg sharedPortIn_r,
    output reg addrTrapIrq_r,
    output reg trapAbort_r,
    output reg resetOut_r
);

// line vector order: 0 = line 0, 1 = line 1, 2 = line 2, 3 = line 3, 4 = line 5
localparam L0 = 0;
localparam L1 = 1;
localparam L2 = 2;
localparam L3 = 3;
localparam L5 = 4;

// apb access states
localparam ST_IDLE = 2'b01;
localparam ST_DONE = 2'b10;

reg [1:0] apbState_r;
reg [1:0] apbState_nxt;

// control registers
reg [7:0] ctrlReg_r;
reg [6:0] enableReg_r;
reg [1:0] modeReg_r;
reg [4:0] latch_nxt;

// pin synchronisers
reg [4:0] pinMeta_r;
reg [4:0] pinSync_r;
reg lfcMeta_r;
reg lfcSync_r;
reg lfcPrev_r;

wire [4:0] pinRaw;
wire [4:0] riseEdge;
wire [4:0] fallEdge;
wire [4:0] lineLevel;
wire [4:0] edgeHit;
wire [4:0] enableFlags;
wire [39:0] acceptCounts;
wire sampleTick;
wire slowMode;
wire line0PinSel;
wire [7:0] line1Count;
wire [7:0] fastCountL05;
wire [7:0] fastCountL23;
wire [7:0] slowCount;

// apb decode
wire [9:0] regIndex;
wire wordAligned;
wire hitCtrl;
wire hitEnable;
wire hitLatch;
wire hitMode;
wire hitAny;
wire accessNow;
wire writeNow;
reg [31:0] readMux;

assign pinRaw = {extLine5Pin, extLine3Pin, extLine2Pin, extLine1Pin, extLine0Pin};

always @(posedge ref_clk) begin
    if (sys_rst) begin
        pinMeta_r <= 5'h1F;
        pinSync_r <= 5'h1F;
        lfcMeta_r <= 1'b0;
        lfcSync_r <= 1'b0;
        lfcPrev_r <= 1'b0;
    end else begin
        pinMeta_r <= pinRaw;
        pinSync_r <= pinMeta_r;
        lfcMeta_r <= lowFreqClockPin;
        lfcSync_r <= lfcMeta_r;
        lfcPrev_r <= lfcSync_r;
    end
end

assign slowMode = modeReg_r[`EIC_MODE_SLOW];
assign line0PinSel = ctrlReg_r[`EIC_CTRL_L0_PIN];

// slow modes sample on low clock
assign sampleTick = slowMode ? (lfcSync_r & ~lfcPrev_r) : 1'b1;

assign fastCountL05 = `EIC_CNT_L05;
assign fastCountL23 = `EIC_CNT_L23;
assign slowCount = `EIC_CNT_FS;

assign line1Count = ctrlReg_r[`EIC_CTRL_L1_FILT] ? `EIC_CNT_L1S : `EIC_CNT_L1L;

assign acceptCounts[8*L0 +: 8] = slowMode ? slowCount : fastCountL05;
assign acceptCounts[8*L1 +: 8] = slowMode ? slowCount : line1Count;
assign acceptCounts[8*L2 +: 8] = slowMode ? slowCount : fastCountL23;
assign acceptCounts[8*L3 +: 8] = slowMode ? slowCount : fastCountL23;
assign acceptCounts[8*L5 +: 8] = slowMode ? slowCount : fastCountL05;

genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_filt
        eic_noise_filter u_filt (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .lineIn(pinSync_r[gi]),
            .sampleTick(sampleTick),
            .acceptCount(acceptCounts[8*gi +: 8]),
            .lineLevel_r(lineLevel[gi]),
            .riseEdge_r(riseEdge[gi]),
            .fallEdge_r(fallEdge[gi])
        );
    end
endgenerate

// line 0 falling only, pin select gates
// lines 1-3 edge by select bit
assign edgeHit[L0] = fallEdge[L0] & line0PinSel;
assign edgeHit[L1] = ctrlReg_r[`EIC_CTRL_L1_EDGE] ? fallEdge[L1] : riseEdge[L1];
assign edgeHit[L2] = ctrlReg_r[`EIC_CTRL_L2_EDGE] ? fallEdge[L2] : riseEdge[L2];
assign edgeHit[L3] = ctrlReg_r[`EIC_CTRL_L3_EDGE] ? fallEdge[L3] : riseEdge[L3];
assign edgeHit[L5] = fallEdge[L5];

// apb address decode
assign regIndex = paddr[11:2];
assign wordAligned = (paddr[1:0] == 2'b00);
assign hitCtrl = wordAligned & (regIndex == `EIC_IDX_CTRL);
assign hitEnable = wordAligned & (regIndex == `EIC_IDX_ENABLE);
assign hitLatch = wordAligned & (regIndex == `EIC_IDX_LATCH);
assign hitMode = wordAligned & (regIndex == `EIC_IDX_MODE);
assign hitAny = hitCtrl | hitEnable | hitLatch | hitMode;
assign accessNow = psel & penable & (apbState_r == ST_IDLE);
assign writeNow = psel & penable & pready & pwrite & hitAny;

always @* begin
    readMux = 32'h0000_0000;
    if (hitCtrl) begin
        readMux[7:0] = ctrlReg_r & `EIC_CTRL_MASK;
    end else if (hitEnable) begin
        readMux[6:0] = enableReg_r;
    end else if (hitLatch) begin
        readMux[4:0] = irqLatch_r;
    end else if (hitMode) begin
        readMux[1:0] = modeReg_r;
    end
end

// one wait state: answer comes one cycle into the access phase
always @* begin
    apbState_nxt = apbState_r;
    case (apbState_r)
        ST_IDLE: begin
            if (accessNow) begin
                apbState_nxt = ST_DONE;
            end
        end
        ST_DONE: begin
            apbState_nxt = ST_IDLE;
        end
        default: begin
            apbState_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge ref_clk) begin
    if (sys_rst) begin
        apbState_r <= ST_IDLE;
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        apbState_r <= apbState_nxt;
        pready <= accessNow;
        pslverr <= accessNow & ~hitAny;
        if (accessNow & ~pwrite) begin
            prdata <= readMux;
        end
    end
end

// writes commit only at the edge that shows pready, as the master sees it
// shared pin comes up as port input
always @(posedge ref_clk) begin
    if (sys_rst) begin
        ctrlReg_r <= `EIC_CTRL_RESET;
        enableReg_r <= `EIC_ENABLE_RESET;
        modeReg_r <= `EIC_MODE_RESET;
    end else if (writeNow) begin
        if (hitCtrl) begin
            ctrlReg_r <= pwdata[7:0] & `EIC_CTRL_MASK;
        end
        if (hitEnable) begin
            enableReg_r <= pwdata[6:0];
        end
        if (hitMode) begin
            modeReg_r <= pwdata[1:0];
        end
    end
end

// latch holds until accept or clear
// software writes 0 to clear; writing 1 does nothing, so no false set
always @* begin
    latch_nxt = irqLatch_r & ~irqAccept;
    if (writeNow & hitLatch) begin
        latch_nxt = latch_nxt & pwdata[4:0];
    end
    latch_nxt = latch_nxt | edgeHit;
end

always @(posedge ref_clk) begin
    if (sys_rst) begin
        irqLatch_r <= 5'h00;
    end else begin
        irqLatch_r <= latch_nxt;
    end
end

assign enableFlags = enableReg_r[`EIC_EN_FLAG_LO +: 5];

always @(posedge ref_clk) begin
    if (sys_rst) begin
        irqRequest_r <= 5'h00;
    end else begin
        irqRequest_r[L0] <= enableReg_r[`EIC_EN_MASTER] & enableFlags[L0] & line0PinSel & irqLatch_r[L0];
        irqRequest_r[L1] <= enableReg_r[`EIC_EN_MASTER] & enableFlags[L1] & irqLatch_r[L1];
        irqRequest_r[L2] <= enableReg_r[`EIC_EN_MASTER] & enableFlags[L2] & irqLatch_r[L2];
        irqRequest_r[L3] <= enableReg_r[`EIC_EN_MASTER] & enableFlags[L3] & ~enableReg_r[`EIC_EN_VEC14_SEL]
            & irqLatch_r[L3];
        irqRequest_r[L5] <= enableReg_r[`EIC_EN_MASTER] & enableFlags[L5] & irqLatch_r[L5];
    end
end

// port reads the pin whether or not line 0 is selected
always @(posedge ref_clk) begin
    if (sys_rst) begin
        sharedPortIn_r <= 1'b1;
    end else begin
        sharedPortIn_r <= pinSync_r[L0];
    end
end

// address trap: routed by the mode bit standing in for watchdog control
always @(posedge ref_clk) begin
    if (sys_rst) begin
        addrTrapIrq_r <= 1'b0;
        trapAbort_r <= 1'b0;
        resetOut_r <= 1'b0;
    end else begin
        resetOut_r <= fetchTrapPulse & ~modeReg_r[`EIC_MODE_TRAP_IRQ];
        if (fetchTrapPulse & modeReg_r[`EIC_MODE_TRAP_IRQ]) begin
            addrTrapIrq_r <= 1'b1;
        end else if (trapAck) begin
            addrTrapIrq_r <= 1'b0;
        end
        trapAbort_r <= fetchTrapPulse & modeReg_r[`EIC_MODE_TRAP_IRQ] & nmiInService;
    end
end

endmodule

// *** verilog/eic_map.vh ***
// register offsets, field positions, reset values and filter counts
`ifndef EIC_MAP_VH
`define EIC_MAP_VH

// register indices; byte address is four times the index
`define EIC_IDX_CTRL 10'h037
`define EIC_IDX_ENABLE 10'h038
`define EIC_IDX_LATCH 10'h039
`define EIC_IDX_MODE 10'h03A

// ext_irq_ctrl_reg fields
`define EIC_CTRL_L1_FILT 7
`define EIC_CTRL_L0_PIN 6
`define EIC_CTRL_L3_EDGE 3
`define EIC_CTRL_L2_EDGE 2
`define EIC_CTRL_L1_EDGE 1
`define EIC_CTRL_MASK 8'hCE
`define EIC_CTRL_RESET 8'h00

// enable register fields
`define EIC_EN_MASTER 0
`define EIC_EN_FLAG_LO 1
`define EIC_EN_VEC14_SEL 6
`define EIC_ENABLE_RESET 7'h00

// mode register fields
`define EIC_MODE_SLOW 0
`define EIC_MODE_TRAP_IRQ 1
`define EIC_MODE_RESET 2'h0

// filter times in clock periods as printed (fc); slow times in half fs periods
`define EIC_L05_REJ_FC 2
`define EIC_L05_ACC_FC 7
`define EIC_L1L_REJ_FC 63
`define EIC_L1L_ACC_FC 193
`define EIC_L1S_REJ_FC 15
`define EIC_L1S_ACC_FC 49
`define EIC_L23_REJ_FC 7
`define EIC_L23_ACC_FC 25
`define EIC_FS_REJ_HALF 2
`define EIC_FS_ACC_HALF 7
`define EIC_L1_SWITCH_FC 26
`define EIC_LATCH_EXTRA_FS 6

// chosen filter counts, each inside its reject..accept window
`define EIC_CNT_L05 8'h04
`define EIC_CNT_L1L 8'h80
`define EIC_CNT_L1S 8'h20
`define EIC_CNT_L23 8'h10
`define EIC_CNT_FS 8'h02

`endif

// *** verilog/eic_noise_filter.v ***
// digital noise filter with edge pulses for one interrupt line
`timescale 1ns/1ps
module eic_noise_filter (
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // sampled line and sample strobe
    input wire lineIn,
    input wire sampleTick,
    input wire [7:0] acceptCount,
    // filtered results
    output reg lineLevel_r,
    output reg riseEdge_r,
    output reg fallEdge_r
);

reg [7:0] stableCnt_r;

always @(posedge ref_clk) begin
    if (sys_rst) begin
        lineLevel_r <= 1'b1;
        stableCnt_r <= 8'h00;
        riseEdge_r <= 1'b0;
        fallEdge_r <= 1'b0;
    end else begin
        riseEdge_r <= 1'b0;
        fallEdge_r <= 1'b0;
        // a level differing for acceptCount samples is taken; any bounce restarts
        if (lineIn == lineLevel_r) begin
            stableCnt_r <= 8'h00;
        end else if (sampleTick) begin
            if (stableCnt_r >= acceptCount - 8'h01) begin
                lineLevel_r <= lineIn;
                stableCnt_r <= 8'h00;
                riseEdge_r <= lineIn;
                fallEdge_r <= ~lineIn;
            end else begin
                stableCnt_r <= stableCnt_r + 8'h01;
            end
        end
    end
end

endmodule

// *** dv/eic_pin_src.sv ***
// pin-side signal sources for the conditioner
`timescale 1ns/1ps
module eic_pin_src (
    // clock
    input wire logic ref_clk,
    // pins, idle high
    output logic extLine0Pin,
    output logic extLine1Pin,
    output logic extLine2Pin,
    output logic extLine3Pin,
    output logic extLine5Pin,
    // slow crystal
    output logic lowFreqClockPin
);
    logic [4:0] lvl = 5'h1F;
    int fsCnt = 0;
    assign {extLine5Pin, extLine3Pin, extLine2Pin, extLine1Pin, extLine0Pin} = lvl;
    // crystal runs free, 32 fast cycles a period
    assign lowFreqClockPin = fsCnt < 16;
    always @(posedge ref_clk) begin
        fsCnt <= (fsCnt + 1) % 32;
    end
    task automatic pulse(input int idx, input int width);
        @(posedge ref_clk);
        lvl[idx] <= 1'b0;
        repeat (width) @(posedge ref_clk);
        lvl[idx] <= 1'b1;
    endtask
endmodule

// *** dv/eic_checker.sv ***
// assertions on the conditioner ports
`timescale 1ns/1ps
module eic_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // pins and core
    input wire logic extLine0Pin,
    input wire logic extLine5Pin,
    input wire logic fetchTrapPulse,
    input wire logic nmiInService,
    input wire logic [4:0] irqAccept,
    // results
    input wire logic [4:0] irqRequest_r,
    input wire logic [4:0] irqLatch_r,
    input wire logic sharedPortIn_r,
    input wire logic addrTrapIrq_r,
    input wire logic trapAbort_r,
    input wire logic resetOut_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence pinLow;
        (!extLine0Pin) [*5];
    endsequence
    sequence nmiTrap;
        fetchTrapPulse && nmiInService;
    endsequence
    trap_any_a: assert property (fetchTrapPulse |=> resetOut_r || addrTrapIrq_r)
        else $error("trap gave no response");
    reset_cause_a: assert property (resetOut_r |-> $past(fetchTrapPulse))
        else $error("reset output without trap");
    trap_irq_cause_a: assert property ($rose(addrTrapIrq_r) |-> $past(fetchTrapPulse) && !resetOut_r)
        else $error("trap interrupt without trap");
    trap_abort_a: assert property (nmiTrap |=> trapAbort_r || resetOut_r)
        else $error("trap did not abort service");
    abort_cause_a: assert property (trapAbort_r |-> $past(fetchTrapPulse && nmiInService) && addrTrapIrq_r)
        else $error("abort without trap in service");
    port_input_a: assert property (pinLow |-> !sharedPortIn_r)
        else $error("port input does not follow pin");
    line0_edge_a: assert property ($rose(irqLatch_r[0]) |-> !$past(extLine0Pin, 7))
        else $error("line0 latch without low pulse");
    line5_filter_a: assert property ($rose(irqLatch_r[4]) |-> !$past(extLine5Pin, 7))
        else $error("line5 latch without low pulse");
    latch_hold_a: assert property ((|($past(irqLatch_r) & ~irqLatch_r & ~$past(irqAccept)))
        |-> $past(psel && penable && pwrite))
        else $error("latch dropped without clear");
    request_gate_a: assert property ((irqRequest_r & ~$past(irqLatch_r)) == 5'h00)
        else $error("request without latch");
endmodule
bind eic_top eic_checker chk_i (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .extLine0Pin,
    .extLine5Pin, .fetchTrapPulse, .nmiInService, .irqAccept, .irqRequest_r, .irqLatch_r,
    .sharedPortIn_r, .addrTrapIrq_r, .trapAbort_r, .resetOut_r);

// *** dv/eic_top_tb.sv ***
// self-checking bench for the external interrupt conditioner
`timescale 1ns/1ps
`include "eic_map.vh"
module eic_top_tb;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, extLine0Pin, extLine1Pin, extLine2Pin, extLine3Pin, extLine5Pin;
    logic lowFreqClockPin, fetchTrapPulse = 0, nmiInService = 0, trapAck = 0;
    logic [4:0] irqAccept = 5'h00, irqRequest_r, irqLatch_r;
    logic sharedPortIn_r, addrTrapIrq_r, trapAbort_r, resetOut_r;
    int errCount = 0, totalChecks = 0;
    localparam logic [11:0] CTRL = {`EIC_IDX_CTRL, 2'b00};
    localparam logic [11:0] EN = {`EIC_IDX_ENABLE, 2'b00};
    localparam logic [11:0] LAT = {`EIC_IDX_LATCH, 2'b00};
    localparam logic [11:0] MODE = {`EIC_IDX_MODE, 2'b00};
    always #4 ref_clk = ~ref_clk;
    eic_pin_src src (.ref_clk, .extLine0Pin, .extLine1Pin, .extLine2Pin, .extLine3Pin, .extLine5Pin,
        .lowFreqClockPin);
    eic_top dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .extLine0Pin, .extLine1Pin, .extLine2Pin, .extLine3Pin, .extLine5Pin, .lowFreqClockPin,
        .fetchTrapPulse, .nmiInService, .trapAck, .irqAccept, .irqRequest_r, .irqLatch_r,
        .sharedPortIn_r, .addrTrapIrq_r, .trapAbort_r, .resetOut_r);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // master holds the request until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic e);
        xfer(0, a, 32'h0000_0000);
        chk(what, exp, rd);
        chk("slverr", e, er);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic pulseCore(input logic t, input logic nmi, input logic [4:0] acc);
        @(posedge ref_clk);
        {fetchTrapPulse, trapAck, nmiInService, irqAccept} <= {t, !t, nmi, acc};
        @(posedge ref_clk);
        {fetchTrapPulse, trapAck, irqAccept} <= 7'h00;
        @(posedge ref_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        idle(2);
        sys_rst <= 0;
        for (int i = 0; i < 4; i++) begin
            rdChk("reset reg", CTRL + 12'(4 * i), 32'h0000_0000, 1'h0);
        end
        chk("port input", 1'h1, sharedPortIn_r);
        rdChk("unmapped", 12'h0F0, 32'h0000_0000, 1'h1);
        rdChk("unaligned", CTRL + 12'h001, 32'h0000_0000, 1'h1);
        xfer(1, CTRL, 32'h0000_00FF);
        rdChk("ctrl bits", CTRL, 32'h0000_00CE, 1'h0);
        xfer(1, CTRL, 32'h0000_0000);
        src.pulse(0, 10);
        idle(200);
        chk("line0 off", 5'h00, irqLatch_r);
        xfer(1, CTRL, 32'h0000_0044);
        src.pulse(0, 10);
        src.pulse(4, 1);
        src.pulse(2, 5);
        idle(200);
        chk("glitches", 5'h01, irqLatch_r);
        src.pulse(4, 8);
        src.pulse(2, 30);
        src.pulse(3, 30);
        idle(10);
        chk("edge sel", 5'h15, irqLatch_r);
        idle(200);
        chk("rising l3", 5'h1D, irqLatch_r);
        xfer(1, CTRL, 32'h0000_0046);
        src.pulse(1, 60);
        idle(200);
        chk("l1 long", 5'h1D, irqLatch_r);
        xfer(1, CTRL, 32'h0000_00C6);
        idle(26);
        src.pulse(1, 60);
        idle(200);
        chk("l1 short", 5'h1F, irqLatch_r);
        rdChk("latch reg", LAT, 32'h0000_001F, 1'h0);
        xfer(1, EN, 32'h0000_0011);
        idle(2);
        chk("req l3", 5'h08, irqRequest_r);
        xfer(1, EN, 32'h0000_0051);
        idle(2);
        chk("vec14 sel", 5'h00, irqRequest_r);
        xfer(1, EN, 32'h0000_003F);
        idle(2);
        chk("req all", 5'h1F, irqRequest_r);
        xfer(1, EN, 32'h0000_003E);
        idle(2);
        chk("no master", 5'h00, irqRequest_r);
        pulseCore(0, 0, 5'h04);
        chk("accept", 5'h1B, irqLatch_r);
        xfer(1, LAT, 32'h0000_001E);
        idle(1);
        chk("sw clear", 5'h1A, irqLatch_r);
        pulseCore(1, 0, 5'h00);
        chk("reset out", 1'h1, resetOut_r);
        xfer(1, MODE, 32'h0000_0002);
        pulseCore(1, 1, 5'h00);
        chk("abort", 1'h1, trapAbort_r);
        chk("trap irq", 1'h1, addrTrapIrq_r);
        pulseCore(0, 0, 5'h00);
        chk("trap ack", 1'h0, addrTrapIrq_r);
        xfer(1, LAT, 32'h0000_0000);
        xfer(1, MODE, 32'h0000_0001);
        src.pulse(4, 10);
        idle(300);
        chk("slow glitch", 5'h00, irqLatch_r);
        src.pulse(4, 120);
        idle(300);
        chk("slow pulse", 5'h10, irqLatch_r);
        results();
    end
    initial begin
        idle(20000);
        errCount++;
        results();
    end
endmodule
